// >>> hw/esc_core.sv
// normal-mode serial command decoder of the rotary encoder
`timescale 1ns/1ps

// Summary of operation
// - frame is 5 command bits msb first, then 16 data bits, under chip select
// - code 00000 returns lock, gain level, angle, parity in bit 0
// - code 00001 returns lock, gain level, turn count, parity
// - readout parity bit makes the whole word even
// - lock flag set only while the converter is locked
// - code 00100 returns turn count high byte, angle low byte, no parity
// - code 00011 stores present angle and returns it with parity
// - store reply bits 15..13: storage supply, main supply, stored flag
// - code 10001 bit 15 enters sleep, cleared bit leaves sleep
// - lock reads low in angle and turn readouts while asleep
// - code 10101 bit 10 triggers digital reset
// - code 10111 loads threshold bits 15..9, gain bits 8..6
// - threshold resets to 4 and never goes below 4
// - code 00111 returns threshold and gain in write layout with parity
// - debounce on after reset, bit of 10011; output moves after 2 equal values
// - 10011 reload bit pulses a memory reread request
// - 10011 clear bit resets the turn counter to 0
// - 10110 cosine, 10010 sine: disable bit 2k+1, invert bit 2k
// - invert flips element polarity, disable removes it from channel
// - 00110 and 00010 read element setup; setup resets to 0
module esc_core (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chip_select,
	input wire logic serial_clk,
	input wire logic bidir_serial_line_in,
	output logic bidir_serial_line_out,
	output logic bidir_serial_line_oe,
	input wire logic [7:0] angle_in,
	input wire logic [5:0] gain_level_in,
	input wire logic adc_locked,
	input wire logic backup_supply_ok,
	input wire logic main_supply_ok,
	input wire logic turn_up,
	input wire logic turn_down,
	input wire logic [7:0] element_signs,
	output logic [7:0] angle_out,
	output logic signed [4:0] cos_sum,
	output logic signed [4:0] sin_sum,
	output logic sleep_request,
	output logic digital_reset,
	output logic memory_reload,
	output logic [6:0] wake_threshold,
	output logic [2:0] path_gain,
	output logic output_debounce_enable
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [2:0] cs_sync_r;
	logic [2:0] clk_sync_r;
	logic [1:0] din_sync_r;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cs_sync_r <= 3'h0;
			clk_sync_r <= 3'h0;
			din_sync_r <= 2'h0;
		end else begin
			cs_sync_r <= {cs_sync_r[1:0], chip_select};
			clk_sync_r <= {clk_sync_r[1:0], serial_clk};
			din_sync_r <= {din_sync_r[0], bidir_serial_line_in};
		end
	end
	wire cs_act = cs_sync_r[1];
	wire cs_rise = cs_sync_r[1] & ~cs_sync_r[2];
	wire sclk_rise = clk_sync_r[1] & ~clk_sync_r[2];
	wire sclk_fall = ~clk_sync_r[1] & clk_sync_r[2];
	wire din = din_sync_r[1];

	function automatic logic even_bit(input logic [14:0] v);
		even_bit = ^v;
	endfunction : even_bit

	// ****************************************
	// frame state
	// ****************************************
	typedef enum logic [1:0] {ESC_IDLE, ESC_CMD, ESC_READ, ESC_WRITE} esc_state_e;
	esc_state_e state_r;
	esc_state_e state_nxt;
	logic [4:0] bit_cnt_r;
	logic [4:0] cmd_r;
	logic [15:0] shift_r;
	logic [15:0] reply_r;
	logic out_r;
	logic oe_r;

	logic [6:0] thresh_r;
	logic [2:0] gain_r;
	logic [15:0] cos_setup_r;
	logic [15:0] sin_setup_r;
	logic sleep_r;
	logic debounce_r;
	logic [7:0] turns_r;
	logic [7:0] ref_angle_r;
	logic ref_set_r;
	logic reset_pulse_r;
	logic reload_r;

	wire [4:0] cmd_now = {cmd_r[3:0], din};
	wire cmd_done = (state_r == ESC_CMD) && sclk_rise
		&& (bit_cnt_r == 5'(esc_pkg::CMD_BITS - 1));
	wire is_read = ~cmd_now[4];
	wire frame_end = sclk_rise && (bit_cnt_r == esc_pkg::FRAME_BITS - 5'h01);
	wire write_done = (state_r == ESC_WRITE) && frame_end;
	wire [15:0] wdata = {shift_r[14:0], din};

	wire lock_bit = adc_locked & ~sleep_r;
	wire [14:0] angle_body = {lock_bit, gain_level_in, angle_out};
	wire [14:0] turn_body = {lock_bit, gain_level_in, turns_r};
	wire [14:0] user_body = {thresh_r, gain_r, 5'h00};
	wire [14:0] store_body = {backup_supply_ok, main_supply_ok, 1'b1, 4'h0, angle_out};

	logic [15:0] reply_sel;
	always_comb begin
		case (cmd_now)
			esc_pkg::CMD_ANGLE_READ: reply_sel = {angle_body, even_bit(angle_body)};
			esc_pkg::CMD_TURN_READ: reply_sel = {turn_body, even_bit(turn_body)};
			esc_pkg::CMD_BOTH_READ: reply_sel = {turns_r, angle_out};
			esc_pkg::CMD_STORE_REF: reply_sel = {store_body, even_bit(store_body)};
			esc_pkg::CMD_USER_SETTING_READ: reply_sel = {user_body, even_bit(user_body)};
			esc_pkg::CMD_COS_SETUP_READ: reply_sel = cos_setup_r;
			esc_pkg::CMD_SINE_SETUP_READ: reply_sel = sin_setup_r;
			default: reply_sel = 16'h0000;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ESC_IDLE: if (cs_rise) state_nxt = ESC_CMD;
			ESC_CMD: if (cmd_done) state_nxt = is_read ? ESC_READ : ESC_WRITE;
			ESC_READ: if (frame_end) state_nxt = ESC_IDLE;
			ESC_WRITE: if (frame_end) state_nxt = ESC_IDLE;
			default: state_nxt = ESC_IDLE;
		endcase
		if (!cs_act) state_nxt = ESC_IDLE;
	end

	always_ff @(posedge sys_clk) begin
		if (rst || reset_pulse_r) begin
			state_r <= ESC_IDLE;
			bit_cnt_r <= 5'h00;
			cmd_r <= 5'h00;
			shift_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_r == ESC_IDLE) begin
				bit_cnt_r <= 5'h00;
			end else if (sclk_rise) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
				if (state_r == ESC_CMD) cmd_r <= cmd_now;
				shift_r <= wdata;
			end
		end
	end

	// ****************************************
	// reply driver
	// ****************************************
	// data changes on falling clock so it is stable at the controller's rising sample
	always_ff @(posedge sys_clk) begin
		if (rst || reset_pulse_r) begin
			reply_r <= 16'h0000;
			out_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (!cs_act || state_r == ESC_IDLE) begin
			oe_r <= 1'b0;
			out_r <= 1'b0;
		end else if (cmd_done && is_read) begin
			reply_r <= reply_sel;
		end else if (state_r == ESC_READ && sclk_fall) begin
			// drive only after the command phase
			oe_r <= 1'b1;
			out_r <= reply_r[15];
			reply_r <= {reply_r[14:0], 1'b0};
		end
	end
	assign bidir_serial_line_out = out_r;
	assign bidir_serial_line_oe = oe_r;

	// ****************************************
	// write decode
	// ****************************************
	// only listed codes strobe a register
	wire wr_user = write_done && (cmd_r == esc_pkg::CMD_USER_SETTING_WRITE);
	wire wr_cos = write_done && (cmd_r == esc_pkg::CMD_COS_SETUP_WRITE);
	wire wr_sin = write_done && (cmd_r == esc_pkg::CMD_SINE_SETUP_WRITE);
	wire wr_test = write_done && (cmd_r == esc_pkg::CMD_TEST_SETTING);
	wire wr_filter = write_done && (cmd_r == esc_pkg::CMD_FILTER_AND_CLEAR);
	wire wr_power = write_done && (cmd_r == esc_pkg::CMD_POWER_CONFIG);
	wire store_now = cmd_done && (cmd_now == esc_pkg::CMD_STORE_REF);
	wire [6:0] thresh_w = wdata[15:9];

	always_ff @(posedge sys_clk) begin
		if (rst || reset_pulse_r) begin
			thresh_r <= esc_pkg::THRESH_RESET;
			gain_r <= esc_pkg::GAIN_RESET;
			cos_setup_r <= esc_pkg::SETUP_RESET;
			sin_setup_r <= esc_pkg::SETUP_RESET;
			sleep_r <= 1'b0;
			debounce_r <= esc_pkg::DEBOUNCE_RESET;
			ref_angle_r <= 8'h00;
			ref_set_r <= 1'b0;
			reload_r <= 1'b0;
		end else begin
			reload_r <= 1'b0;
			if (wr_user) begin
				thresh_r <= (thresh_w < esc_pkg::THRESH_MIN) ? esc_pkg::THRESH_MIN : thresh_w;
				gain_r <= wdata[8:6];
			end
			if (wr_cos) cos_setup_r <= wdata;
			if (wr_sin) sin_setup_r <= wdata;
			if (wr_power) sleep_r <= wdata[esc_pkg::BIT_SLEEP];
			if (wr_filter) begin
				debounce_r <= wdata[esc_pkg::BIT_DEBOUNCE];
				reload_r <= wdata[esc_pkg::BIT_MEM_RELOAD];
			end
			if (store_now) begin
				ref_angle_r <= angle_out;
				ref_set_r <= 1'b1;
			end
		end
	end

	// reset pulse outlives one cycle only; this block is cleared by rst alone, not by the pulse
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reset_pulse_r <= 1'b0;
		end else begin
			reset_pulse_r <= wr_test & wdata[esc_pkg::BIT_GEN_RST];
		end
	end

	// ****************************************
	// turn counter and angle debounce
	// ****************************************
	logic [7:0] cand_r;
	always_ff @(posedge sys_clk) begin
		if (rst || reset_pulse_r) begin
			turns_r <= 8'h00;
			angle_out <= 8'h00;
			cand_r <= 8'h00;
		end else begin
			if (wr_filter && wdata[esc_pkg::BIT_TURN_CLEAR]) turns_r <= 8'h00;
			else if (turn_up && !turn_down) turns_r <= turns_r + 8'h01;
			else if (turn_down && !turn_up) turns_r <= turns_r - 8'h01;
			cand_r <= angle_in;
			// two equal new samples before change
			if (!debounce_r || (angle_in == cand_r)) angle_out <= angle_in;
		end
	end

	// ****************************************
	// hall array combination
	// ****************************************
	function automatic logic signed [4:0] channel_sum(input logic [15:0] setup,
		input logic [7:0] signs);
		logic signed [4:0] acc;
		acc = 5'sd0;
		for (int k = 0; k < 8; k++) begin
			if (!setup[2*k+1]) begin
				acc = (signs[k] ^ setup[2*k]) ? acc - 5'sd1 : acc + 5'sd1;
			end
		end
		channel_sum = acc;
	endfunction : channel_sum

	assign cos_sum = channel_sum(cos_setup_r, element_signs);
	assign sin_sum = channel_sum(sin_setup_r, element_signs);
	assign sleep_request = sleep_r;
	assign digital_reset = reset_pulse_r;
	assign memory_reload = reload_r;
	assign wake_threshold = thresh_r;
	assign path_gain = gain_r;
	assign output_debounce_enable = debounce_r;
endmodule : esc_core

// >>> include/esc_pkg.sv
// constants for the encoder serial command decoder
package esc_pkg;
	localparam logic [4:0] CMD_ANGLE_READ = 5'h00;
	localparam logic [4:0] CMD_TURN_READ = 5'h01;
	localparam logic [4:0] CMD_SINE_SETUP_READ = 5'h02;
	localparam logic [4:0] CMD_STORE_REF = 5'h03;
	localparam logic [4:0] CMD_BOTH_READ = 5'h04;
	localparam logic [4:0] CMD_COS_SETUP_READ = 5'h06;
	localparam logic [4:0] CMD_USER_SETTING_READ = 5'h07;
	localparam logic [4:0] CMD_POWER_CONFIG = 5'h11;
	localparam logic [4:0] CMD_SINE_SETUP_WRITE = 5'h12;
	localparam logic [4:0] CMD_FILTER_AND_CLEAR = 5'h13;
	localparam logic [4:0] CMD_TEST_SETTING = 5'h15;
	localparam logic [4:0] CMD_COS_SETUP_WRITE = 5'h16;
	localparam logic [4:0] CMD_USER_SETTING_WRITE = 5'h17;
	localparam int CMD_BITS = 5;
	localparam int DATA_BITS = 16;
	localparam logic [4:0] FRAME_BITS = 5'h15;
	localparam int BIT_SLEEP = 15;
	localparam int BIT_GEN_RST = 10;
	localparam int BIT_MEM_RELOAD = 15;
	localparam int BIT_TURN_CLEAR = 14;
	localparam int BIT_DEBOUNCE = 13;
	localparam logic [6:0] THRESH_RESET = 7'h04;
	localparam logic [6:0] THRESH_MIN = 7'h04;
	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [15:0] SETUP_RESET = 16'h0000;
	localparam logic DEBOUNCE_RESET = 1'b1;
endpackage : esc_pkg

// >>> bench/esc_ctrl_model.sv
// serial controller model that frames commands for the decoder
`timescale 1ns/1ps
module esc_ctrl_model (
	input wire logic sys_clk,
	input wire logic line,
	output logic cs,
	output logic sclk,
	output logic dout
);
	logic den = 1'b0;
	logic dbit = 1'b0;
	logic rel = 1'b0;
	initial begin
		cs = 1'b0;
		sclk = 1'b0;
	end
	// a released line toggles so that a stale bit never reads as valid
	always @(posedge sys_clk) rel <= ~rel;
	assign dout = den ? dbit : rel;
	task automatic xfer(input logic [4:0] c, input logic [15:0] w, output logic [15:0] r);
		logic [20:0] f;
		f = {c, w};
		r = 16'h0000;
		@(posedge sys_clk) cs <= 1'b1;
		repeat (6) @(posedge sys_clk);
		for (int i = 20; i >= 0; i--) begin
			den <= (i > 15) || c[4];
			dbit <= f[i];
			repeat (4) @(posedge sys_clk);
			sclk <= 1'b1;
			if (i < 16) r[i] = line;
			repeat (4) @(posedge sys_clk);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge sys_clk);
		cs <= 1'b0;
		den <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask : xfer
endmodule : esc_ctrl_model

// >>> bench/esc_core_props.sv
// port assertions of the serial command decoder
`timescale 1ns/1ps
module esc_core_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chip_select,
	input wire logic bidir_serial_line_oe,
	input wire logic [7:0] angle_in,
	input wire logic [7:0] angle_out,
	input wire logic output_debounce_enable,
	input wire logic [6:0] wake_threshold,
	input wire logic [2:0] path_gain,
	input wire logic sleep_request,
	input wire logic digital_reset,
	input wire logic memory_reload,
	input wire logic signed [4:0] cos_sum
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_oe_idle_low: assert property (!chip_select [*4] |-> !bidir_serial_line_oe)
		else $error("line driven outside a frame");
	a_oe_in_frame: assert property ($rose(bidir_serial_line_oe) |-> chip_select)
		else $error("line driven without chip select");
	a_thresh_floor: assert property (wake_threshold >= esc_pkg::THRESH_MIN)
		else $error("threshold below floor");
	a_reset_state: assert property (disable iff (1'b0) rst |=> wake_threshold == 7'h04 &&
		path_gain == 3'h0 && output_debounce_enable && !sleep_request)
		else $error("bad reset state");
	a_dreset_pulse: assert property (digital_reset |=> !digital_reset)
		else $error("digital reset longer than one cycle");
	a_reload_pulse: assert property ($rose(memory_reload) |=> $fell(memory_reload))
		else $error("reload longer than one cycle");
	a_idle_stable: assert property (!chip_select [*8] |-> $stable(wake_threshold) &&
		$stable(path_gain) && $stable(sleep_request))
		else $error("setting moved outside a frame");
	a_debounce_two: assert property ($changed(angle_out) && $past(output_debounce_enable)
		|-> $past(angle_in) == $past(angle_in, 2) || $past(angle_in, 2) == $past(angle_in, 3))
		else $error("angle moved on a single sample");
	a_sum_range: assert property (cos_sum >= -5'sh08 && cos_sum <= 5'sh08)
		else $error("cosine sum out of range");
endmodule : esc_core_props
bind esc_core esc_core_props u_props (.sys_clk(sys_clk), .rst(rst), .chip_select(chip_select),
	.bidir_serial_line_oe(bidir_serial_line_oe), .angle_in(angle_in), .angle_out(angle_out),
	.output_debounce_enable(output_debounce_enable), .wake_threshold(wake_threshold),
	.path_gain(path_gain), .sleep_request(sleep_request), .digital_reset(digital_reset),
	.memory_reload(memory_reload), .cos_sum(cos_sum));

// >>> bench/esc_core_bench.sv
// self-checking bench of the serial command decoder
`timescale 1ns/1ps
module esc_core_bench;
	logic sys_clk, rst, cs, sclk, dout, line, bidir_serial_line, oe, lock, bok, mok, tup, tdn;
	logic sleep, drst, mrel, deb;
	logic [7:0] ang, angq, signs;
	logic [5:0] gl;
	logic signed [4:0] cs_sum, sn_sum;
	logic [6:0] thr;
	logic [2:0] gain;
	logic [15:0] r;
	int fail_count = 0;
	int checked = 0;
	int drst_seen = 0;
	int mrel_seen = 0;
	// the device wins the line only while it enables its driver
	assign line = oe ? bidir_serial_line : dout;
	esc_ctrl_model ctrl (.sys_clk(sys_clk), .line(line), .cs(cs), .sclk(sclk), .dout(dout));
	esc_core dut (.sys_clk(sys_clk), .rst(rst), .chip_select(cs), .serial_clk(sclk),
		.bidir_serial_line_in(line), .bidir_serial_line_out(bidir_serial_line), .bidir_serial_line_oe(oe),
		.angle_in(ang), .gain_level_in(gl), .adc_locked(lock), .backup_supply_ok(bok),
		.main_supply_ok(mok), .turn_up(tup), .turn_down(tdn), .element_signs(signs),
		.angle_out(angq), .cos_sum(cs_sum), .sin_sum(sn_sum), .sleep_request(sleep),
		.digital_reset(drst), .memory_reload(mrel), .wake_threshold(thr), .path_gain(gain),
		.output_debounce_enable(deb));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (drst) drst_seen++;
		if (mrel) mrel_seen++;
	end
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	function automatic logic [15:0] par(input logic [15:0] w);
		return {w[15:1], ^w[15:1]};
	endfunction : par
	task automatic end_of_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	task automatic rd_chk(input string n, input logic [4:0] c, input logic [15:0] e);
		ctrl.xfer(c, 16'h0000, r);
		cmp(n, e, r);
	endtask : rd_chk
	task automatic pulse_turn(input logic up);
		@(posedge sys_clk) if (up) tup <= 1'b1; else tdn <= 1'b1;
		@(posedge sys_clk) tup <= 1'b0;
		tdn <= 1'b0;
	endtask : pulse_turn
	task automatic t_reads;
		rd_chk("angle", 5'h00, par({1'b1, gl, ang, 1'b0}));
		repeat (3) pulse_turn(1'b1);
		pulse_turn(1'b0);
		rd_chk("turn", 5'h01, par({1'b1, gl, 8'h02, 1'b0}));
		rd_chk("both", 5'h04, {8'h02, ang});
		ctrl.xfer(5'h13, 16'h6000, r);
		rd_chk("cleared", 5'h04, {8'h00, ang});
		@(posedge sys_clk) lock <= 1'b0;
		rd_chk("unlocked", 5'h00, par({1'b0, gl, ang, 1'b0}));
		@(posedge sys_clk) lock <= 1'b1;
		@(posedge sys_clk) mok <= 1'b0;
		rd_chk("store", 5'h03, par({3'h5, 4'h0, ang, 1'b0}));
		@(posedge sys_clk) mok <= 1'b1;
	endtask : t_reads
	task automatic t_sleep;
		ctrl.xfer(5'h11, 16'h8000, r);
		cmp("sleep", 16'h0001, {15'h0000, sleep});
		rd_chk("asleep", 5'h01, par({1'b0, gl, 8'h00, 1'b0}));
		ctrl.xfer(5'h11, 16'h0000, r);
		cmp("awake", 16'h0000, {15'h0000, sleep});
	endtask : t_sleep
	task automatic t_user;
		rd_chk("user rst", 5'h07, par(16'h0800));
		ctrl.xfer(5'h17, {7'h02, 3'h5, 6'h3f}, r);
		cmp("clamp", {6'h00, thr, gain}, {6'h00, 7'h04, 3'h5});
		ctrl.xfer(5'h17, {7'h7f, 3'h2, 6'h3f}, r);
		rd_chk("user", 5'h07, par({7'h7f, 3'h2, 6'h00}));
	endtask : t_user
	task automatic t_elem;
		rd_chk("cos rst", 5'h06, 16'h0000);
		rd_chk("sin rst", 5'h02, 16'h0000);
		cmp("sum", 16'(cs_sum), 16'h0000);
		ctrl.xfer(5'h16, 16'h0055, r);
		ctrl.xfer(5'h12, 16'h5500, r);
		cmp("inv", 16'(cs_sum * sn_sum), 16'hffc0);
		rd_chk("cos", 5'h06, 16'h0055);
		rd_chk("sin", 5'h02, 16'h5500);
		ctrl.xfer(5'h16, 16'h00aa, r);
		ctrl.xfer(5'h12, 16'haa00, r);
		cmp("dis", 16'(cs_sum * sn_sum), 16'hfff0);
	endtask : t_elem
	task automatic t_misc;
		ctrl.xfer(5'h14, 16'hffff, r);
		ctrl.xfer(5'h10, 16'hffff, r);
		cmp("resv", {8'h00, sleep, thr}, {8'h00, 1'b0, 7'h7f});
		rd_chk("undef", 5'h05, 16'h0000);
		@(posedge sys_clk) ang <= 8'h3c;
		@(posedge sys_clk) ang <= 8'ha5;
		#1;
		cmp("glitch now", 16'h00a5, {8'h00, angq});
		repeat (6) @(posedge sys_clk);
		cmp("glitch", {8'h00, angq}, 16'h00a5);
		ctrl.xfer(5'h13, 16'h8000, r);
		cmp("reload", 16'(mrel_seen), 16'h0001);
		cmp("deb off", {15'h0000, deb}, 16'h0000);
		@(posedge sys_clk) ang <= 8'h3c;
		@(posedge sys_clk) ang <= 8'ha5;
		#1;
		cmp("no debounce", 16'h003c, {8'h00, angq});
		repeat (4) @(posedge sys_clk);
		ctrl.xfer(5'h15, 16'h0400, r);
		cmp("dreset", 16'(drst_seen), 16'h0001);
		rd_chk("user dr", 5'h07, par(16'h0800));
		rd_chk("cos dr", 5'h06, 16'h0000);
	endtask : t_misc
	initial begin
		rst = 1'b1;
		ang = 8'ha5;
		gl = 6'h2b;
		lock = 1'b1;
		bok = 1'b1;
		mok = 1'b1;
		tup = 1'b0;
		tdn = 1'b0;
		signs = 8'h0f;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		t_user();
		t_reads();
		t_sleep();
		t_elem();
		t_misc();
		end_of_test();
	end
	initial begin
		#900000;
		fail_count++;
		end_of_test();
	end
endmodule : esc_core_bench
